// ### hw/spc_regs.sv
/*
 * spc_regs: speaker gain boost, speaker mode and pop suppression,
 * power enables with thermal shutdown, and first clock-control register.
 * Also makes the slow timeout clock tick and the output clock tick.
 * Assumes all inputs synchronous to clk_in; the register master follows the
 * one-cycle strobe port, read data one cycle after the read strobe.
 */
//
// Contract
// R1 - DC boost field bits 5:3, reset 011
// R2 - AC boost field bits 2:0, reset 011
// R3 - Class D drives pop bits from enable
// R4 - software clears pop bits before AB enable
// R5 - both thermal enables gate outputs off when hot
// R6 - read-only temperature status bit, writes ignored
// R7 - slow clock rate 125Hz to 1kHz, reset 00
// R8 - temperature status registered on system clock
`timescale 1ns/1ps

module spc_regs #(
    parameter int unsigned SLOW_CYCLES = spc_pkg::SLOW_BASE_CYCLES
) (
    input  wire logic                    clk_in,
    input  wire logic                    reset_in,
    input  wire spc_pkg::spc_bus_req_t   bus_req_in,
    input  wire logic                    over_temp_in,
    output logic [spc_pkg::DATA_W-1:0]   rd_data_out,
    output spc_pkg::spc_analog_ctl_t     analog_ctl_out,
    output logic                         slow_timeout_clock_out,
    output logic                         output_clock_out,
    output logic                         irq_out
);
    import spc_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0]     gain_r;
        logic [DATA_W-1:0]     mode_r;
        logic [DATA_W-1:0]     pwr_r;
        logic [DATA_W-1:0]     clk_r;
        logic [IRQ_W-1:0]      irq_stat_r;
        logic [IRQ_W-1:0]      irq_mask_r;
        logic                  over_temp_r;
        logic                  temp_stat_r;
        logic [DATA_W-1:0]     rdata_r;
        logic                  irq_r;
        spc_analog_ctl_t       ctl_r;
        logic [SLOW_CNT_W-1:0] slow_cnt_r;
        logic                  slow_tick_r;
        logic [3:0]            op_cnt_r;
        logic                  op_tick_r;
    } spc_state_t;

    localparam spc_state_t STATE_RST = '{
        gain_r:      RST_GAIN,
        mode_r:      RST_MODE,
        pwr_r:       RST_PWR,
        clk_r:       RST_CLK,
        irq_stat_r:  '0,
        irq_mask_r:  '0,
        over_temp_r: 1'b0,
        temp_stat_r: 1'b0,
        rdata_r:     '0,
        irq_r:       1'b0,
        ctl_r:       '0,
        slow_cnt_r:  '0,
        slow_tick_r: 1'b0,
        op_cnt_r:    '0,
        op_tick_r:   1'b0
    };

    spc_state_t s_r;
    spc_state_t s_nxt;

    // last count of the output clock divider (divide ratio minus one) for each code
    function automatic logic [3:0] op_div_last(input logic [2:0] code);
        logic [4:0] div;
        div = 5'd1;
        unique case (code)
            3'd0: div = 5'd1;
            3'd1: div = 5'd2;
            3'd2: div = 5'd3;
            3'd3: div = 5'd4;
            3'd4: div = 5'd6;
            3'd5: div = 5'd8;
            3'd6: div = 5'd12;
            3'd7: div = 5'd16;
        endcase
        return 4'(div - 5'd1);
    endfunction

    // merge a write into the writable bits only
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                                input logic [DATA_W-1:0] wdata,
                                                input logic [DATA_W-1:0] wmask);
        return (old & ~wmask) | (wdata & wmask);
    endfunction

    logic                  wr_gain;
    logic                  wr_mode;
    logic                  wr_pwr;
    logic                  wr_clk;
    logic                  temp_now;
    logic [IRQ_W-1:0]      irq_evt;
    logic [IRQ_W-1:0]      irq_clr;
    logic [SLOW_CNT_W-1:0] slow_last;
    logic                  hot_off;
    logic                  class_d;

    always_comb begin
        s_nxt   = s_r;
        wr_gain = bus_req_in.wr && (bus_req_in.addr == OFS_GAIN);
        wr_mode = bus_req_in.wr && (bus_req_in.addr == OFS_MODE);
        wr_pwr  = bus_req_in.wr && (bus_req_in.addr == OFS_PWR);
        wr_clk  = bus_req_in.wr && (bus_req_in.addr == OFS_CLK);
        irq_clr = '0;
        if (bus_req_in.wr && (bus_req_in.addr == OFS_IRQ_STAT)) begin
            irq_clr = bus_req_in.wdata[IRQ_W-1:0];
        end

        // reserved boost codes are stored as written
        if (wr_gain) begin
            s_nxt.gain_r = merge(s_r.gain_r, bus_req_in.wdata, WMASK_GAIN); // R1 R2
        end
        if (wr_mode) begin
            s_nxt.mode_r = merge(s_r.mode_r, bus_req_in.wdata, WMASK_MODE);
        end
        if (wr_pwr) begin
            s_nxt.pwr_r = merge(s_r.pwr_r, bus_req_in.wdata, WMASK_PWR); // R6
        end
        if (wr_clk) begin
            s_nxt.clk_r = merge(s_r.clk_r, bus_req_in.wdata, WMASK_CLK); // R7
        end
        if (bus_req_in.wr && (bus_req_in.addr == OFS_IRQ_MASK)) begin
            s_nxt.irq_mask_r = bus_req_in.wdata[IRQ_W-1:0];
        end

        // thermal status
        s_nxt.over_temp_r = over_temp_in; // R8
        temp_now          = s_r.pwr_r[TSENSE_EN_BIT] && s_r.over_temp_r;
        s_nxt.temp_stat_r = temp_now; // R6
        irq_evt           = '0;
        irq_evt[IRQ_OVER_TEMP] = temp_now && !s_r.temp_stat_r;
        irq_evt[IRQ_TEMP_OK]   = !temp_now && s_r.temp_stat_r;
        // set wins over a clear in the same cycle
        s_nxt.irq_stat_r  = (s_r.irq_stat_r & ~irq_clr) | irq_evt;
        s_nxt.irq_r       = |(s_nxt.irq_stat_r & s_nxt.irq_mask_r);

        // read port
        s_nxt.rdata_r = '0;
        if (bus_req_in.rd) begin
            unique case (bus_req_in.addr)
                OFS_GAIN:     s_nxt.rdata_r = s_r.gain_r;
                OFS_MODE:     s_nxt.rdata_r = s_r.mode_r;
                OFS_PWR: begin
                    s_nxt.rdata_r = s_r.pwr_r;
                    s_nxt.rdata_r[TEMP_STAT_BIT] = s_r.temp_stat_r; // R6
                end
                OFS_CLK:      s_nxt.rdata_r = s_r.clk_r;
                OFS_IRQ_STAT: s_nxt.rdata_r = DATA_W'(s_r.irq_stat_r);
                OFS_IRQ_MASK: s_nxt.rdata_r = DATA_W'(s_r.irq_mask_r);
                default:      s_nxt.rdata_r = '0;
            endcase
        end

        // analogue controls from the updated registers
        hot_off = s_nxt.pwr_r[TSHUT_EN_BIT] && s_nxt.pwr_r[TSENSE_EN_BIT]
                  && s_nxt.over_temp_r; // R5
        class_d = !s_nxt.mode_r[CLASS_SEL_BIT];
        s_nxt.ctl_r.dc_boost  = s_nxt.gain_r[DC_BOOST_LSB +: 3]; // R1
        s_nxt.ctl_r.ac_boost  = s_nxt.gain_r[AC_BOOST_LSB +: 3]; // R2
        s_nxt.ctl_r.class_ab  = s_nxt.mode_r[CLASS_SEL_BIT];
        if (class_d) begin
            s_nxt.ctl_r.antipop_invert_mute    = !s_nxt.pwr_r[SPK_EN_BIT]; // R3
            s_nxt.ctl_r.antipop_output_control = !s_nxt.pwr_r[SPK_EN_BIT]; // R3
        end else begin
            // class AB: software clears both before enabling the speaker
            s_nxt.ctl_r.antipop_invert_mute    = s_nxt.mode_r[INV_MUTE_BIT]; // R4
            s_nxt.ctl_r.antipop_output_control = s_nxt.mode_r[OUT_CTRL_BIT]; // R4
        end
        s_nxt.ctl_r.converter_enable          = s_nxt.pwr_r[CONV_EN_BIT] && !hot_off; // R5
        s_nxt.ctl_r.speaker_gain_stage_enable = s_nxt.pwr_r[GAIN_EN_BIT] && !hot_off; // R5
        s_nxt.ctl_r.speaker_output_enable     = s_nxt.pwr_r[SPK_EN_BIT] && !hot_off; // R5
        s_nxt.ctl_r.line_output_enable        = s_nxt.pwr_r[LINE_EN_BIT] && !hot_off; // R5
        s_nxt.ctl_r.thermal_shutdown_active   = hot_off;
        s_nxt.ctl_r.master_clock_halve        = s_nxt.clk_r[MCLK_HALVE_BIT];

        // slow timeout tick, period halves per code step
        slow_last = SLOW_CNT_W'((SLOW_CYCLES >> s_r.clk_r[SLOW_SEL_LSB +: 2]) - 1); // R7
        if (s_r.slow_cnt_r >= slow_last) begin
            s_nxt.slow_cnt_r  = '0;
            s_nxt.slow_tick_r = 1'b1;
        end else begin
            s_nxt.slow_cnt_r  = s_r.slow_cnt_r + 1'b1;
            s_nxt.slow_tick_r = 1'b0;
        end

        // output clock tick, one pulse per divide period
        if (s_r.op_cnt_r >= op_div_last(s_r.clk_r[OP_DIV_LSB +: 3])) begin
            s_nxt.op_cnt_r  = '0;
            s_nxt.op_tick_r = 1'b1;
        end else begin
            s_nxt.op_cnt_r  = s_r.op_cnt_r + 1'b1;
            s_nxt.op_tick_r = 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            s_r <= STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rd_data_out            = s_r.rdata_r;
    assign analog_ctl_out         = s_r.ctl_r;
    assign slow_timeout_clock_out = s_r.slow_tick_r;
    assign output_clock_out       = s_r.op_tick_r;
    assign irq_out                = s_r.irq_r;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    // helper: cycles since the last slow tick
    logic [SLOW_CNT_W-1:0] gap_cnt_r;
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            gap_cnt_r <= '0;
        end else if (s_r.slow_tick_r) begin
            gap_cnt_r <= '0;
        end else begin
            gap_cnt_r <= gap_cnt_r + 1'b1;
        end
    end

    sequence gain_write_s;
        bus_req_in.wr && bus_req_in.addr == OFS_GAIN;
    endsequence

    sequence gain_read_s;
        bus_req_in.rd && bus_req_in.addr == OFS_GAIN;
    endsequence

    a_dc_boost_write: assert property ( // R1
        gain_write_s ##1 gain_read_s |=> rd_data_out[5:3] == $past(bus_req_in.wdata[5:3], 2))
        else $error("dc boost readback differs from write");

    a_ac_boost_out: assert property ( // R2
        gain_write_s |=> analog_ctl_out.ac_boost == $past(bus_req_in.wdata[2:0]))
        else $error("ac boost output not updated by write");

    a_classd_antipop: assert property ( // R3
        !s_r.mode_r[CLASS_SEL_BIT] && $stable(s_r.pwr_r) [*2]
        |-> analog_ctl_out.antipop_invert_mute == !s_r.pwr_r[SPK_EN_BIT]
            && analog_ctl_out.antipop_output_control == !s_r.pwr_r[SPK_EN_BIT])
        else $error("class d pop bits not following speaker enable");

    a_classab_antipop: assert property ( // R4
        s_r.mode_r[CLASS_SEL_BIT] && $stable(s_r.mode_r)
        |-> analog_ctl_out.antipop_invert_mute == s_r.mode_r[INV_MUTE_BIT])
        else $error("class ab pop bit not taken from register");

    a_thermal_off: assert property ( // R5
        s_r.pwr_r[TSHUT_EN_BIT] && s_r.pwr_r[TSENSE_EN_BIT] && s_r.over_temp_r
        && $stable(s_r.pwr_r) |-> !analog_ctl_out.speaker_output_enable
        && !analog_ctl_out.converter_enable && analog_ctl_out.thermal_shutdown_active)
        else $error("outputs stay on while over temperature");

    a_temp_status_read: assert property ( // R6
        bus_req_in.rd && bus_req_in.addr == OFS_PWR
        |=> rd_data_out[TEMP_STAT_BIT] == $past(s_r.temp_stat_r))
        else $error("temperature status bit reads wrong");

    a_temp_sync: assert property ( // R8
        s_r.pwr_r[TSENSE_EN_BIT] ##0 over_temp_in ##1 s_r.pwr_r[TSENSE_EN_BIT] |=> s_r.temp_stat_r)
        else $error("temperature status not two cycles after input");

    a_slow_period: assert property ( // R7
        s_r.slow_tick_r && $stable(s_r.clk_r[9:8]) ##1 !s_r.slow_tick_r
        |-> gap_cnt_r == '0)
        else $error("slow tick counter not restarted");

    a_slow_rate: assert property ( // R7
        $rose(s_r.slow_tick_r) |-> $past(gap_cnt_r) <= SLOW_CNT_W'(SLOW_CYCLES - 1))
        else $error("slow tick later than the slowest rate");

    a_irq_level: assert property (
        |(s_r.irq_stat_r & s_r.irq_mask_r) |-> irq_out)
        else $error("interrupt low with unmasked status set");

    a_irq_quiet: assert property (
        !(|(s_r.irq_stat_r & s_r.irq_mask_r)) |-> !irq_out)
        else $error("interrupt high with no unmasked status set");

    // helper sequences for the status clear and shutdown checks
    sequence stat_clear_s;
        bus_req_in.wr && bus_req_in.addr == OFS_IRQ_STAT;
    endsequence

    sequence hot_s;
        s_r.pwr_r[TSHUT_EN_BIT] && s_r.pwr_r[TSENSE_EN_BIT] && s_r.over_temp_r;
    endsequence

    a_read_idle: assert property (
        !bus_req_in.rd |=> rd_data_out == '0)
        else $error("read data not cleared after idle cycle");

    // a clear in the same cycle as the onset must lose
    a_irq_set_wins: assert property (
        s_r.pwr_r[TSENSE_EN_BIT] && s_r.over_temp_r && !s_r.temp_stat_r
        |=> s_r.irq_stat_r[IRQ_OVER_TEMP])
        else $error("over temperature onset not recorded");

    a_stat_clear: assert property (
        stat_clear_s ##0 (bus_req_in.wdata[IRQ_OVER_TEMP] && s_r.temp_stat_r)
        |=> !s_r.irq_stat_r[IRQ_OVER_TEMP])
        else $error("status bit not cleared by writing one");

    a_op_div_one: assert property (
        (s_r.clk_r[OP_DIV_LSB +: 3] == 3'd0) [*2] |-> output_clock_out)
        else $error("undivided output clock tick missing");

    a_class_bit_out: assert property ( // R3
        analog_ctl_out.class_ab == s_r.mode_r[CLASS_SEL_BIT])
        else $error("class select output differs from register");

    // speaker enable passes straight through while not hot
    a_enable_follow: assert property ( // R5
        !(s_r.pwr_r[TSHUT_EN_BIT] && s_r.pwr_r[TSENSE_EN_BIT] && s_r.over_temp_r)
        |-> analog_ctl_out.speaker_output_enable == s_r.pwr_r[SPK_EN_BIT])
        else $error("speaker enable output differs while cool");

    a_gain_line_off: assert property ( // R5
        hot_s |-> !analog_ctl_out.speaker_gain_stage_enable && !analog_ctl_out.line_output_enable)
        else $error("gain stage or line output on while over temperature");

    a_temp_bit_ro: assert property ( // R6
        bus_req_in.wr && bus_req_in.addr == OFS_PWR |=> !s_r.pwr_r[TEMP_STAT_BIT])
        else $error("temperature status bit took a write");

    a_halve_out: assert property (
        analog_ctl_out.master_clock_halve == s_r.clk_r[MCLK_HALVE_BIT])
        else $error("clock halving output differs from register");

endmodule

// ### common/spc_pkg.sv
/*
 * spc_pkg: constants and carrier types for the speaker, power and clock
 * control register slice.
 * Assumes a 125 MHz system clock and a 16-bit register port with 8-bit
 * addresses.
 */
package spc_pkg;

    localparam int unsigned CLK_HZ            = 125_000_000;
    localparam int unsigned SLOW_BASE_HZ      = 125;
    localparam int unsigned SLOW_BASE_CYCLES  = CLK_HZ / SLOW_BASE_HZ;
    localparam int unsigned SLOW_CNT_W        = 20;
    localparam int unsigned ADDR_W            = 8;
    localparam int unsigned DATA_W            = 16;

    // register offsets
    localparam logic [7:0]  OFS_GAIN          = 8'h09;
    localparam logic [7:0]  OFS_MODE          = 8'h0A;
    localparam logic [7:0]  OFS_PWR           = 8'h0B;
    localparam logic [7:0]  OFS_CLK           = 8'h0C;
    localparam logic [7:0]  OFS_IRQ_STAT      = 8'h10;
    localparam logic [7:0]  OFS_IRQ_MASK      = 8'h11;

    // reset values
    localparam logic [15:0] RST_GAIN          = 16'h001B;
    localparam logic [15:0] RST_MODE          = 16'h0018;
    localparam logic [15:0] RST_PWR           = 16'h0180;
    localparam logic [15:0] RST_CLK           = 16'h0000;

    // writable bits per register
    localparam logic [15:0] WMASK_GAIN        = 16'h003F;
    localparam logic [15:0] WMASK_MODE        = 16'h0058;
    localparam logic [15:0] WMASK_PWR         = 16'h0197;
    localparam logic [15:0] WMASK_CLK         = 16'h1F80;

    // field positions
    localparam int unsigned DC_BOOST_LSB      = 3;
    localparam int unsigned AC_BOOST_LSB      = 0;
    localparam int unsigned CLASS_SEL_BIT     = 6;
    localparam int unsigned INV_MUTE_BIT      = 4;
    localparam int unsigned OUT_CTRL_BIT      = 3;
    localparam int unsigned TSHUT_EN_BIT      = 8;
    localparam int unsigned TSENSE_EN_BIT     = 7;
    localparam int unsigned TEMP_STAT_BIT     = 6;
    localparam int unsigned LINE_EN_BIT       = 4;
    localparam int unsigned GAIN_EN_BIT       = 2;
    localparam int unsigned SPK_EN_BIT        = 1;
    localparam int unsigned CONV_EN_BIT       = 0;
    localparam int unsigned OP_DIV_LSB        = 10;
    localparam int unsigned SLOW_SEL_LSB      = 8;
    localparam int unsigned MCLK_HALVE_BIT    = 7;

    // interrupt bits
    localparam int unsigned IRQ_W             = 2;
    localparam int unsigned IRQ_OVER_TEMP     = 0;
    localparam int unsigned IRQ_TEMP_OK       = 1;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } spc_bus_req_t;

    typedef struct packed {
        logic [2:0] dc_boost;
        logic [2:0] ac_boost;
        logic       class_ab;
        logic       antipop_invert_mute;
        logic       antipop_output_control;
        logic       converter_enable;
        logic       speaker_gain_stage_enable;
        logic       speaker_output_enable;
        logic       line_output_enable;
        logic       thermal_shutdown_active;
        logic       master_clock_halve;
    } spc_analog_ctl_t;

endpackage

// ### verif/spc_regs_test.sv
/*
 * spc_regs_test: self-checking bench for the speaker, power and clock
 * register slice, with read results checked from a queue of expectations.
 * Assumes spc_pkg and spc_regs are compiled before this file.
 */
`timescale 1ns/1ps
module spc_regs_test;
    import spc_pkg::*;
    localparam int unsigned SC    = 64;
    localparam int          ND[8] = '{1, 2, 3, 4, 6, 8, 12, 16};
    logic                   clk_in;
    logic                   reset_in;
    spc_bus_req_t           bus;
    logic                   over_temp_in;
    logic [15:0]            rd_data_out;
    spc_analog_ctl_t        ctl;
    logic                   slow_tick;
    logic                   out_tick;
    logic                   irq_out;
    int                     fails;
    int                     cmp_count;
    logic [15:0]            exp_q[$];
    logic                   rd_q = 1'b0;
    logic [31:0]            seed;
    logic [15:0]            d;
    logic [7:0]             a;

    spc_regs #(.SLOW_CYCLES(SC)) i_dut (
        .clk_in                 (clk_in),
        .reset_in               (reset_in),
        .bus_req_in             (bus),
        .over_temp_in           (over_temp_in),
        .rd_data_out            (rd_data_out),
        .analog_ctl_out         (ctl),
        .slow_timeout_clock_out (slow_tick),
        .output_clock_out       (out_tick),
        .irq_out                (irq_out)
    );

    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction

    function automatic logic [15:0] wm(logic [7:0] ad);
        return ad == OFS_GAIN ? WMASK_GAIN : ad == OFS_MODE ? WMASK_MODE :
               ad == OFS_PWR ? WMASK_PWR : ad == OFS_CLK ? WMASK_CLK : 16'h0000;
    endfunction

    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wr(logic [7:0] ad, logic [15:0] wd);
        @(posedge clk_in);
        bus.addr  <= ad;
        bus.wdata <= wd;
        bus.wr    <= 1'b1;
        @(posedge clk_in);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(logic [7:0] ad, logic [15:0] e);
        @(posedge clk_in);
        bus.addr <= ad;
        bus.rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_in);
        bus.rd <= 1'b0;
    endtask

    // write then read back with no gap between the strobes
    task automatic wr_rd(logic [7:0] ad, logic [15:0] wd, logic [15:0] e);
        @(posedge clk_in);
        bus.addr  <= ad;
        bus.wdata <= wd;
        bus.wr    <= 1'b1;
        @(posedge clk_in);
        bus.wr <= 1'b0;
        bus.rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_in);
        bus.rd <= 1'b0;
    endtask

    // fields: dc, ac, {class_ab, mute, ctrl}, {conv, gain, spk, line}, shutdown, halve
    task automatic ana(logic [2:0] dc, ac, m, logic [3:0] en, logic sh, mh);
        #1;
        chk("analog_ctl", 16'({dc, ac, m, en, sh, mh}), 16'(ctl));
    endtask

    task automatic heat(logic v);
        @(posedge clk_in);
        over_temp_in <= v;
        repeat (3) @(posedge clk_in);
    endtask

    task automatic irq(logic e);
        repeat (2) @(posedge clk_in);
        #1;
        chk("irq_out", 16'(e), 16'(irq_out));
    endtask

    // waits for three ticks; the last interval is the settled period
    task automatic period(logic which, int e);
        int n;
        for (int k = 0; k < 3; k++) begin
            n = 0;
            do begin
                @(posedge clk_in);
                #1;
                n++;
            end while ((which ? out_tick : slow_tick) !== 1'b1 && n < 200);
            if (n >= 200) begin
                fails++;
                test_done();
            end
        end
        chk(which ? "output_clock" : "slow_clock", 16'(e), 16'(n));
    endtask

    // read data stand only in the cycle after the read strobe
    always @(posedge clk_in) begin
        if (rd_q)
            chk("rd_data", exp_q.pop_front(), rd_data_out);
        else if (!reset_in)
            chk("rd_idle", 16'h0000, rd_data_out);
        rd_q = bus.rd;
    end

    initial begin
        seed = 32'h0000_0021;
        bus = '0;
        over_temp_in = 1'b0;
        reset_in = 1'b1;
        fails = 0;
        cmp_count = 0;
        repeat (10) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        ana(3'h3, 3'h3, 3'h3, 4'h0, 1'h0, 1'h0);
        rd(OFS_GAIN, RST_GAIN);
        rd(OFS_MODE, RST_MODE);
        rd(OFS_PWR, RST_PWR);
        rd(OFS_CLK, RST_CLK);
        rd(OFS_IRQ_STAT, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            a = OFS_GAIN + 8'(i);
            d = rnd();
            wr(a, d);
            rd(a, d & wm(a));
        end
        wr(OFS_MODE, RST_MODE);
        wr(OFS_PWR, RST_PWR);
        wr(OFS_CLK, RST_CLK);
        for (int i = 0; i < 8; i++) begin
            d = rnd();
            d[5:0] = {3'(i), 3'(7 - i)};
            wr_rd(OFS_GAIN, d, {10'h000, d[5:0]});
            ana(3'(i), 3'(7 - i), 3'h3, 4'h0, 1'h0, 1'h0);
        end
        wr(OFS_PWR, 16'h0182);
        ana(3'h7, 3'h0, 3'h0, 4'h2, 1'h0, 1'h0);
        rd(OFS_MODE, RST_MODE);
        wr(OFS_PWR, RST_PWR);
        wr(OFS_MODE, 16'h0058);
        ana(3'h7, 3'h0, 3'h7, 4'h0, 1'h0, 1'h0);
        wr(OFS_MODE, 16'h0040);
        wr(OFS_PWR, 16'h0182);
        ana(3'h7, 3'h0, 3'h4, 4'h2, 1'h0, 1'h0);
        for (int i = 0; i < 8; i++) begin
            wr(OFS_CLK, {3'h0, 3'(i), 2'(i), 1'(i), 7'h00});
            ana(3'h7, 3'h0, 3'h4, 4'h2, 1'h0, 1'(i));
            period(1'b0, SC >> (i % 4));
            period(1'b1, ND[i]);
        end
        wr(OFS_IRQ_MASK, 16'h0003);
        rd(OFS_IRQ_MASK, 16'h0003);
        wr(OFS_PWR, 16'h0197);
        ana(3'h7, 3'h0, 3'h4, 4'hF, 1'h0, 1'h1);
        heat(1'b1);
        ana(3'h7, 3'h0, 3'h4, 4'h0, 1'h1, 1'h1);
        irq(1'b1);
        rd(OFS_PWR, 16'h01D7);
        rd(OFS_IRQ_STAT, 16'h0001);
        wr(OFS_IRQ_STAT, 16'h0001);
        irq(1'b0);
        heat(1'b0);
        ana(3'h7, 3'h0, 3'h4, 4'hF, 1'h0, 1'h1);
        irq(1'b1);
        rd(OFS_IRQ_STAT, 16'h0002);
        wr(OFS_IRQ_STAT, 16'h0003);
        wr(OFS_PWR, 16'h0117);
        heat(1'b1);
        ana(3'h7, 3'h0, 3'h4, 4'hF, 1'h0, 1'h1);
        rd(OFS_PWR, 16'h0117);
        rd(OFS_IRQ_STAT, 16'h0000);
        heat(1'b0);
        wr(OFS_IRQ_MASK, 16'h0000);
        wr(OFS_PWR, 16'h00D7);
        rd(OFS_PWR, 16'h0097);
        heat(1'b1);
        ana(3'h7, 3'h0, 3'h4, 4'hF, 1'h0, 1'h1);
        rd(OFS_PWR, 16'h00D7);
        rd(OFS_IRQ_STAT, 16'h0001);
        irq(1'b0);
        reset_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        ana(3'h3, 3'h3, 3'h3, 4'h0, 1'h1, 1'h0);
        rd(OFS_IRQ_MASK, 16'h0000);
        repeat (3) @(posedge clk_in);
        chk("pending_reads", 16'h0000, 16'(exp_q.size()));
        test_done();
    end
endmodule
